// ===== pkg/lgr_cfg.svh
// Register indices, field positions and reset values of the line gain bank
`ifndef LGR_CFG_SVH
`define LGR_CFG_SVH

// Register indices; byte address is four times the index
`define LGR_IDX_BIAS    7'h04
`define LGR_IDX_MIDRAIL 7'h05
`define LGR_IDX_LEFT    7'h3b
`define LGR_IDX_RIGHT   7'h3c
`define LGR_IDX_STATUS  7'h40

// Line gain register fields
`define LGR_BIT_SILENCE 8
`define LGR_BIT_APPLY   7
`define LGR_BIT_GATE    6
`define LGR_GAIN_HI     5
`define LGR_GAIN_RESET  6'h39

// Reference and bias fields
`define LGR_BIT_BUFFER  6
`define LGR_DIV_HI      2
`define LGR_DIV_LO      1
`define LGR_BIT_SOURCE  0
`define LGR_BIT_BIAS    0
`define LGR_DIV_RESET   2'h0

// Status register fields
`define LGR_STAT_RGAIN  8
`define LGR_STAT_LPEND  16
`define LGR_STAT_RPEND  17

// Bus answers
`define LGR_RESP_OKAY   2'h0
`define LGR_RESP_SLVERR 2'h2

`endif

// ===== pkg/lgr_pkg.sv
// Types shared by the line gain bank modules
`default_nettype none

package lgr_pkg;
	// One line side as software programs it
	typedef struct packed {
		logic       silence;
		logic       crossingGate;
		logic [5:0] gainCode;
	} lgr_line_s;

	// Reference and bias controls driven to the analogue core
	typedef struct packed {
		logic       masterBiasEnable;
		logic       midrailSourceEnable;
		logic [1:0] midrailDividerSelect;
		logic       midrailBufferToUnused;
	} lgr_ref_s;

	// Gain applied at the output stage
	typedef struct packed {
		logic       silence;
		logic [5:0] appliedGain;
		logic       pending;
	} lgr_drive_s;

	// Gain apply sequencer states
	typedef enum logic {LGR_IDLE, LGR_WAIT} lgr_apply_e;
endpackage

`default_nettype wire

// ===== rtl/lgr_apply.sv
// Per-side gain apply sequencer with zero-cross gating and timeout
`timescale 1ns/1ps
`default_nettype none
`include "lgr_cfg.svh"

module lgr_apply (
	input  wire logic       clk,            // System clock
	input  wire logic       rst,            // Async reset, high
	input  wire logic       applyPulse,     // Shared update request
	input  wire logic       crossingGate,   // Zero-cross gating on
	input  wire logic [5:0] storedGain,     // Gain code held in register
	input  wire logic       zeroCross,      // Signal crossed zero
	input  wire logic       timeoutFire,    // Gated timeout tick
	output logic      [5:0] appliedGain,    // Gain at the output
	output logic            pending         // Change still waiting
);
	import lgr_pkg::*;

	// ==========================================================
	// Apply decision
	lgr_apply_e state_reg;
	lgr_apply_e state_next;
	logic [5:0] applied_reg;
	logic [5:0] applied_next;
	wire        gateOpen = zeroCross | timeoutFire;
	wire        fireNow  = applyPulse & ~crossingGate;
	wire        fireWait = (state_reg == LGR_WAIT) & gateOpen;
	wire        doApply  = fireNow | fireWait;

	// New request wins over completion of the old one
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			LGR_IDLE: begin
				if (applyPulse & crossingGate) begin
					state_next = LGR_WAIT;
				end
			end
			LGR_WAIT: begin
				if (doApply & ~(applyPulse & crossingGate)) begin
					state_next = LGR_IDLE;
				end
			end
		endcase
	end

	assign applied_next = doApply ? storedGain : applied_reg;

	// State and applied gain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg   <= LGR_IDLE;
			applied_reg <= `LGR_GAIN_RESET;
		end else begin
			state_reg   <= state_next;
			applied_reg <= applied_next;
		end
	end

	assign appliedGain = applied_reg;
	assign pending     = (state_reg == LGR_WAIT);
endmodule

`default_nettype wire

// ===== rtl/lgr_regs.sv
// Line output gain and analogue reference control registers, AXI4-Lite
//
// Contract
// - Each line side mute bit at bit 8; 1 mutes; resets to 0.
// - Six-bit gain code bits 5:0, -57dB at 0, 1dB steps to +6dB.
// - Both gain codes reset to 111001, unity gain.
// - Writing 1 to shared bit 7 applies both stored gains together.
// - Per-side zero-cross enable at bit 6; resets to 0.
// - Divider select bits 2:1: off, normal, standby, fast; resets 00.
// - Reference bit 0 enables mid-rail source; resets to 0.
// - Reference bit 6 buffers mid-rail to unused pins; resets to 0.
// - Bias register bit 0 enables master bias; resets to 0.
// - Gated change waits for zero crossing or enabled timeout.
// - Gain write without update bit only stores the value.
`timescale 1ns/1ps
`default_nettype none
`include "lgr_cfg.svh"

module lgr_regs (
	input  wire logic        clk,                   // 40 MHz clock
	input  wire logic        rst,                   // Async reset, high
	input  wire logic [8:0]  s_axi_awaddr,          // Write address
	input  wire logic        s_axi_awvalid,         // Write address valid
	output logic             s_axi_awready,         // Write address ready
	input  wire logic [31:0] s_axi_wdata,           // Write data
	input  wire logic [3:0]  s_axi_wstrb,           // Write strobes
	input  wire logic        s_axi_wvalid,          // Write data valid
	output logic             s_axi_wready,          // Write data ready
	output logic [1:0]       s_axi_bresp,           // Write response
	output logic             s_axi_bvalid,          // Write response valid
	input  wire logic        s_axi_bready,          // Write response ready
	input  wire logic [8:0]  s_axi_araddr,          // Read address
	input  wire logic        s_axi_arvalid,         // Read address valid
	output logic             s_axi_arready,         // Read address ready
	output logic [31:0]      s_axi_rdata,           // Read data
	output logic [1:0]       s_axi_rresp,           // Read response
	output logic             s_axi_rvalid,          // Read data valid
	input  wire logic        s_axi_rready,          // Read data ready
	input  wire logic        leftZeroCross,         // Left crossing seen
	input  wire logic        rightZeroCross,        // Right crossing seen
	input  wire logic        crossingTimeoutEnable, // Timeout clock on
	input  wire logic        timeoutTick,           // Timeout expiry tick
	output lgr_pkg::lgr_drive_s leftLine,           // Left output drive
	output lgr_pkg::lgr_drive_s rightLine,          // Right output drive
	output lgr_pkg::lgr_ref_s   refCtrl             // Reference and bias
);
	import lgr_pkg::*;

	// ==========================================================
	// Write channel capture
	logic        awHeld_reg;
	logic [6:0]  awIdx_reg;
	logic        wHeld_reg;
	logic [31:0] wData_reg;
	logic [3:0]  wStrb_reg;
	logic        bValid_reg;
	logic [1:0]  bResp_reg;
	wire awTake  = s_axi_awvalid & ~awHeld_reg;
	wire wTake   = s_axi_wvalid & ~wHeld_reg;
	wire doWrite = awHeld_reg & wHeld_reg & ~bValid_reg;
	assign s_axi_awready = ~awHeld_reg;
	assign s_axi_wready  = ~wHeld_reg;
	assign s_axi_bvalid  = bValid_reg;
	assign s_axi_bresp   = bResp_reg;

	// Index decode shared by both channels
	function automatic logic isMapped(input logic [6:0] idx);
		isMapped = (idx == `LGR_IDX_BIAS) || (idx == `LGR_IDX_MIDRAIL) ||
			(idx == `LGR_IDX_LEFT) || (idx == `LGR_IDX_RIGHT) ||
			(idx == `LGR_IDX_STATUS);
	endfunction

	// Address and data holding, response
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			awIdx_reg  <= 7'h00;
			wHeld_reg  <= 1'b0;
			wData_reg  <= 32'h0000_0000;
			wStrb_reg  <= 4'h0;
			bValid_reg <= 1'b0;
			bResp_reg  <= `LGR_RESP_OKAY;
		end else begin
			if (awTake) begin
				awHeld_reg <= 1'b1;
				awIdx_reg  <= s_axi_awaddr[8:2];
			end else if (doWrite) begin
				awHeld_reg <= 1'b0;
			end
			if (wTake) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_reg <= 1'b0;
			end
			if (doWrite) begin
				bValid_reg <= 1'b1;
				bResp_reg  <= isMapped(awIdx_reg) ?
					`LGR_RESP_OKAY : `LGR_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bValid_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Register write decode
	wire loLane  = wStrb_reg[0];
	wire hiLane  = wStrb_reg[1];
	wire wrBias  = doWrite & (awIdx_reg == `LGR_IDX_BIAS) & loLane;
	wire wrMid   = doWrite & (awIdx_reg == `LGR_IDX_MIDRAIL) & loLane;
	wire wrLeft  = doWrite & (awIdx_reg == `LGR_IDX_LEFT);
	wire wrRight = doWrite & (awIdx_reg == `LGR_IDX_RIGHT);
	wire applyWr = (wrLeft | wrRight) & loLane &
		wData_reg[`LGR_BIT_APPLY];
	lgr_line_s leftCfg_reg;
	lgr_line_s rightCfg_reg;
	lgr_ref_s  ref_reg;
	logic      applyPulse_reg;

	// Line side update from one write, lanes honoured
	function automatic lgr_line_s lineNext(input lgr_line_s cur,
		input logic [31:0] d, input logic lo, input logic hi);
		lineNext = cur;
		if (hi) begin
			lineNext.silence = d[`LGR_BIT_SILENCE];
		end
		if (lo) begin
			lineNext.crossingGate = d[`LGR_BIT_GATE];
			lineNext.gainCode     = d[`LGR_GAIN_HI:0];
		end
	endfunction

	// Stored controls; update bit itself is never stored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			leftCfg_reg    <= '{1'b0, 1'b0, `LGR_GAIN_RESET};
			rightCfg_reg   <= '{1'b0, 1'b0, `LGR_GAIN_RESET};
			ref_reg        <= '{1'b0, 1'b0, `LGR_DIV_RESET, 1'b0};
			applyPulse_reg <= 1'b0;
		end else begin
			if (wrLeft) begin
				leftCfg_reg <= lineNext(leftCfg_reg, wData_reg,
					loLane, hiLane);
			end
			if (wrRight) begin
				rightCfg_reg <= lineNext(rightCfg_reg, wData_reg,
					loLane, hiLane);
			end
			if (wrBias) begin
				ref_reg.masterBiasEnable <= wData_reg[`LGR_BIT_BIAS];
			end
			if (wrMid) begin
				ref_reg.midrailSourceEnable   <=
					wData_reg[`LGR_BIT_SOURCE];
				ref_reg.midrailDividerSelect  <=
					wData_reg[`LGR_DIV_HI:`LGR_DIV_LO];
				ref_reg.midrailBufferToUnused <=
					wData_reg[`LGR_BIT_BUFFER];
			end
			applyPulse_reg <= applyWr;
		end
	end

	// ==========================================================
	// Gain apply per side
	wire       timeoutFire = crossingTimeoutEnable & timeoutTick;
	logic [5:0] leftApplied;
	logic [5:0] rightApplied;
	logic       leftPending;
	logic       rightPending;
	lgr_apply u_left (
		.clk          (clk),
		.rst          (rst),
		.applyPulse   (applyPulse_reg),
		.crossingGate (leftCfg_reg.crossingGate),
		.storedGain   (leftCfg_reg.gainCode),
		.zeroCross    (leftZeroCross),
		.timeoutFire  (timeoutFire),
		.appliedGain  (leftApplied),
		.pending      (leftPending)
	);
	lgr_apply u_right (
		.clk          (clk),
		.rst          (rst),
		.applyPulse   (applyPulse_reg),
		.crossingGate (rightCfg_reg.crossingGate),
		.storedGain   (rightCfg_reg.gainCode),
		.zeroCross    (rightZeroCross),
		.timeoutFire  (timeoutFire),
		.appliedGain  (rightApplied),
		.pending      (rightPending)
	);
	// Mute travels apart from applied gain
	assign leftLine  = '{leftCfg_reg.silence, leftApplied, leftPending};
	assign rightLine = '{rightCfg_reg.silence, rightApplied, rightPending};
	assign refCtrl   = ref_reg;

	// ==========================================================
	// Read channel
	logic        rValid_reg;
	logic [31:0] rData_reg;
	logic [1:0]  rResp_reg;
	wire         arTake = s_axi_arvalid & ~rValid_reg;
	wire  [6:0]  rdIdx  = s_axi_araddr[8:2];
	// Line register image, update bit reads zero
	function automatic logic [31:0] lineImage(input lgr_line_s c);
		lineImage = 32'h0000_0000;
		lineImage[`LGR_BIT_SILENCE]  = c.silence;
		lineImage[`LGR_BIT_GATE]     = c.crossingGate;
		lineImage[`LGR_GAIN_HI:0]    = c.gainCode;
	endfunction

	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		if (rdIdx == `LGR_IDX_BIAS) begin
			rdMux[`LGR_BIT_BIAS] = ref_reg.masterBiasEnable;
		end else if (rdIdx == `LGR_IDX_MIDRAIL) begin
			rdMux[`LGR_BIT_BUFFER] = ref_reg.midrailBufferToUnused;
			rdMux[`LGR_DIV_HI:`LGR_DIV_LO] = ref_reg.midrailDividerSelect;
			rdMux[`LGR_BIT_SOURCE] = ref_reg.midrailSourceEnable;
		end else if (rdIdx == `LGR_IDX_LEFT) begin
			rdMux = lineImage(leftCfg_reg);
		end else if (rdIdx == `LGR_IDX_RIGHT) begin
			rdMux = lineImage(rightCfg_reg);
		end else if (rdIdx == `LGR_IDX_STATUS) begin
			rdMux[`LGR_GAIN_HI:0] = leftApplied;
			rdMux[`LGR_STAT_RGAIN +: 6] = rightApplied;
			rdMux[`LGR_STAT_LPEND] = leftPending;
			rdMux[`LGR_STAT_RPEND] = rightPending;
		end
	end

	// Read data capture and hold
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rValid_reg <= 1'b0;
			rData_reg  <= 32'h0000_0000;
			rResp_reg  <= `LGR_RESP_OKAY;
		end else if (arTake) begin
			rValid_reg <= 1'b1;
			rData_reg  <= rdMux;
			rResp_reg  <= isMapped(rdIdx) ?
				`LGR_RESP_OKAY : `LGR_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_reg <= 1'b0;
		end
	end

	assign s_axi_arready = ~rValid_reg;
	assign s_axi_rvalid  = rValid_reg;
	assign s_axi_rdata   = rData_reg;
	assign s_axi_rresp   = rResp_reg;

	// ==========================================================
	// Assertions
	property p_mute_write;
		@(posedge clk) disable iff (rst)
		wrLeft && hiLane |=> leftLine.silence == $past(wData_reg[8]);
	endproperty
	a_mute_write: assert property (p_mute_write)
		else $error("left silence did not follow write");
	property p_gain_store;
		@(posedge clk) disable iff (rst)
		wrRight && loLane |=> rightCfg_reg.gainCode == $past(wData_reg[5:0]);
	endproperty
	a_gain_store: assert property (p_gain_store)
		else $error("right gain code not stored");
	property p_reset_gain;
		@(posedge clk) disable iff (rst)
		$fell(rst) |-> leftApplied == 6'h39 && rightApplied == 6'h39;
	endproperty
	a_reset_gain: assert property (p_reset_gain)
		else $error("applied gain not unity after reset");
	property p_apply_both;
		@(posedge clk) disable iff (rst)
		applyWr && !leftCfg_reg.crossingGate && !rightCfg_reg.crossingGate
		##1 !leftCfg_reg.crossingGate && !rightCfg_reg.crossingGate
		|=> leftApplied == $past(leftCfg_reg.gainCode) &&
			rightApplied == $past(rightCfg_reg.gainCode);
	endproperty
	a_apply_both: assert property (p_apply_both)
		else $error("update bit did not apply both gains");
	property p_gate_store;
		@(posedge clk) disable iff (rst)
		wrLeft && loLane |=> leftCfg_reg.crossingGate == $past(wData_reg[6]);
	endproperty
	a_gate_store: assert property (p_gate_store)
		else $error("crossing gate not stored");
	property p_ref_write;
		@(posedge clk) disable iff (rst)
		wrMid |=> refCtrl.midrailDividerSelect == $past(wData_reg[2:1]) &&
			refCtrl.midrailSourceEnable == $past(wData_reg[0]) &&
			refCtrl.midrailBufferToUnused == $past(wData_reg[6]);
	endproperty
	a_ref_write: assert property (p_ref_write)
		else $error("reference controls did not follow write");
	property p_bias_write;
		@(posedge clk) disable iff (rst)
		wrBias |=> refCtrl.masterBiasEnable == $past(wData_reg[0]);
	endproperty
	a_bias_write: assert property (p_bias_write)
		else $error("master bias did not follow write");
	property p_gate_hold;
		@(posedge clk) disable iff (rst)
		leftPending && !leftZeroCross && !timeoutFire &&
		!(applyPulse_reg && !leftCfg_reg.crossingGate) |=> $stable(leftApplied);
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("gated gain changed without crossing");
	property p_store_only;
		@(posedge clk) disable iff (rst)
		wrLeft && !applyWr && !applyPulse_reg && !leftPending
		|=> ##1 $stable(leftApplied);
	endproperty
	a_store_only: assert property (p_store_only)
		else $error("gain write without update changed output");
	property p_pulse_once;
		@(posedge clk) disable iff (rst)
		applyPulse_reg |=> !applyPulse_reg;
	endproperty
	a_pulse_once: assert property (p_pulse_once)
		else $error("update pulse longer than one cycle");

	c_apply: cover property (@(posedge clk) disable iff (rst)
		applyPulse_reg ##1 !leftPending);
	c_gated: cover property (@(posedge clk) disable iff (rst)
		leftPending ##1 leftZeroCross ##1 !leftPending);
	c_timeout: cover property (@(posedge clk) disable iff (rst)
		rightPending && timeoutFire);
endmodule

`default_nettype wire

// ===== verification/line_out_gain_and_ref_regs_tb.sv
// Self-checking bench for the line gain and reference register bank
`timescale 1ns/1ps
`default_nettype none
`include "lgr_cfg.svh"

module line_out_gain_and_ref_regs_tb;
	import lgr_pkg::*;

	// ==========================================================
	// Signals
	// ==========================================================
	logic               clk;
	logic               rst;
	logic        [8:0]  awAddr;
	logic               awValid;
	logic               awReady;
	logic        [31:0] wData;
	logic        [3:0]  wStrb;
	logic               wValid;
	logic               wReady;
	logic        [1:0]  bResp;
	logic               bValid;
	logic               bReady;
	logic        [8:0]  arAddr;
	logic               arValid;
	logic               arReady;
	logic        [31:0] rData;
	logic        [1:0]  rResp;
	logic               rValid;
	logic               rReady;
	logic               leftZc;
	logic               rightZc;
	logic               toEnable;
	logic               toTick;
	lgr_drive_s         leftLine;
	lgr_drive_s         rightLine;
	lgr_ref_s           refCtrl;
	int                 nMismatch;
	int                 numChecks;
	logic        [31:0] rd;
	logic        [1:0]  rsp;

	// ==========================================================
	// Clock, 25 ns period
	// ==========================================================
	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	lgr_regs i_dut (
		.clk                  (clk),
		.rst                  (rst),
		.s_axi_awaddr         (awAddr),
		.s_axi_awvalid        (awValid),
		.s_axi_awready        (awReady),
		.s_axi_wdata          (wData),
		.s_axi_wstrb          (wStrb),
		.s_axi_wvalid         (wValid),
		.s_axi_wready         (wReady),
		.s_axi_bresp          (bResp),
		.s_axi_bvalid         (bValid),
		.s_axi_bready         (bReady),
		.s_axi_araddr         (arAddr),
		.s_axi_arvalid        (arValid),
		.s_axi_arready        (arReady),
		.s_axi_rdata          (rData),
		.s_axi_rresp          (rResp),
		.s_axi_rvalid         (rValid),
		.s_axi_rready         (rReady),
		.leftZeroCross        (leftZc),
		.rightZeroCross       (rightZc),
		.crossingTimeoutEnable(toEnable),
		.timeoutTick          (toTick),
		.leftLine             (leftLine),
		.rightLine            (rightLine),
		.refCtrl              (refCtrl)
	);

	// ==========================================================
	// Checking and closing
	// ==========================================================
	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (nMismatch == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Bus tasks, master side
	// ==========================================================
	task automatic axiWrite(input logic [6:0] idx, input logic [31:0] d,
			input logic [1:0] expResp);
		int i;
		@(posedge clk);
		awAddr <= {idx, 2'h0};
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
			if (bValid) begin
				bReady <= 1'b0;
				check("write response", 32'(bResp), 32'(expResp));
				break;
			end
		end
		if (i == 100) begin
			nMismatch++;
			stop_test();
		end
	endtask

	task automatic axiRead(input logic [6:0] idx, output logic [31:0] d,
			output logic [1:0] r);
		int i;
		@(posedge clk);
		arAddr <= {idx, 2'h0};
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (arValid && arReady) arValid <= 1'b0;
			if (rValid) begin
				d = rData;
				r = rResp;
				rReady <= 1'b0;
				break;
			end
		end
		if (i == 100) begin
			nMismatch++;
			stop_test();
		end
	endtask

	// Read a register and compare data and response
	task automatic readCheck(input string what, input logic [6:0] idx,
			input logic [31:0] exp, input logic [1:0] expResp);
		axiRead(idx, rd, rsp);
		check(what, rd, exp);
		check("read response", 32'(rsp), 32'(expResp));
	endtask

	// Line register word: silence, update, gate, gain
	function automatic logic [31:0] lineWord(input logic s, input logic u,
			input logic g, input logic [5:0] gain);
		return {23'h0, s, u, g, gain};
	endfunction

	// One-cycle pulse on the crossing and timeout inputs
	task automatic strobe(input logic lz, input logic rz,
			input logic en, input logic tk);
		@(posedge clk);
		leftZc <= lz;
		rightZc <= rz;
		toEnable <= en;
		toTick <= tk;
		@(posedge clk);
		{leftZc, rightZc, toEnable, toTick} <= 4'h0;
		repeat (2) @(posedge clk);
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		{rst, awValid, wValid, bReady, arValid, rReady} = 6'h20;
		{leftZc, rightZc, toEnable, toTick} = 4'h0;
		awAddr = 9'h0;
		arAddr = 9'h0;
		wData = 32'h0;
		wStrb = 4'h3;
		nMismatch = 0;
		numChecks = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;

		// Reset values
		readCheck("bias reset", `LGR_IDX_BIAS, 32'h0, 2'h0);
		readCheck("midrail reset", `LGR_IDX_MIDRAIL, 32'h0, 2'h0);
		readCheck("left reset", `LGR_IDX_LEFT, 32'h39, 2'h0);
		readCheck("right reset", `LGR_IDX_RIGHT, 32'h39, 2'h0);
		check("ref outputs reset", 32'(refCtrl), 32'h0);
		check("left drive reset", 32'(leftLine), 32'h72);
		check("right drive reset", 32'(rightLine), 32'h72);

		// Every divider code with source and buffer toggled
		for (int c = 0; c < 4; c++) begin
			axiWrite(`LGR_IDX_MIDRAIL, {25'h0, c[0], 3'h0, c[1:0], c[0]},
				2'h0);
			readCheck("midrail", `LGR_IDX_MIDRAIL,
				{25'h0, c[0], 3'h0, c[1:0], c[0]}, 2'h0);
			check("divider out", 32'(refCtrl.midrailDividerSelect),
				32'(c));
			check("source out", 32'(refCtrl.midrailSourceEnable),
				32'(c[0]));
			check("buffer out", 32'(refCtrl.midrailBufferToUnused),
				32'(c[0]));
		end
		// Normal divider with source on before bias is enabled
		axiWrite(`LGR_IDX_MIDRAIL, 32'h3, 2'h0);
		axiWrite(`LGR_IDX_BIAS, 32'hffff_ffff, 2'h0);
		readCheck("bias", `LGR_IDX_BIAS, 32'h1, 2'h0);
		check("bias out", 32'(refCtrl.masterBiasEnable), 32'h1);

		// Store without update, then update from the other side
		axiWrite(`LGR_IDX_LEFT, lineWord(0, 0, 0, 6'h00), 2'h0);
		check("left held", 32'(leftLine.appliedGain), 32'h39);
		axiWrite(`LGR_IDX_RIGHT, lineWord(0, 1, 0, 6'h3f), 2'h0);
		repeat (2) @(posedge clk);
		check("left applied", 32'(leftLine.appliedGain), 32'h00);
		check("right applied", 32'(rightLine.appliedGain), 32'h3f);
		readCheck("update reads 0", `LGR_IDX_RIGHT, 32'h3f, 2'h0);

		// Mute and unmute keep the applied gain
		axiWrite(`LGR_IDX_LEFT, lineWord(1, 0, 0, 6'h00), 2'h0);
		repeat (2) @(posedge clk);
		check("left muted", 32'(leftLine.silence), 32'h1);
		check("gain kept", 32'(leftLine.appliedGain), 32'h00);
		axiWrite(`LGR_IDX_LEFT, lineWord(0, 0, 0, 6'h00), 2'h0);
		repeat (2) @(posedge clk);
		check("left unmuted", 32'(leftLine.silence), 32'h0);
		check("gain restored", 32'(leftLine.appliedGain), 32'h00);

		// Gated left waits for its crossing
		axiWrite(`LGR_IDX_LEFT, lineWord(0, 0, 1, 6'h10), 2'h0);
		axiWrite(`LGR_IDX_RIGHT, lineWord(0, 1, 0, 6'h20), 2'h0);
		repeat (2) @(posedge clk);
		check("right ungated", 32'(rightLine.appliedGain), 32'h20);
		check("left pending", 32'(leftLine.pending), 32'h1);
		check("left waits", 32'(leftLine.appliedGain), 32'h00);
		strobe(1, 0, 0, 0);
		check("left on cross", 32'(leftLine), 32'h20);

		// Both gated; right crosses, left needs an enabled timeout
		axiWrite(`LGR_IDX_RIGHT, lineWord(0, 0, 1, 6'h21), 2'h0);
		axiWrite(`LGR_IDX_LEFT, lineWord(0, 1, 1, 6'h05), 2'h0);
		strobe(0, 1, 0, 1);
		check("right on cross", 32'(rightLine), 32'h42);
		check("left still", 32'(leftLine), 32'h21);
		strobe(0, 0, 1, 1);
		check("left timeout", 32'(leftLine), 32'h0a);
		readCheck("status", `LGR_IDX_STATUS, 32'h2105, 2'h0);

		// Byte lanes: low lane leaves silence, high lane sets only silence
		wStrb <= 4'h1;
		axiWrite(`LGR_IDX_RIGHT, lineWord(1, 0, 0, 6'h0c), 2'h0);
		readCheck("low lane", `LGR_IDX_RIGHT, 32'h0c, 2'h0);
		wStrb <= 4'h2;
		axiWrite(`LGR_IDX_RIGHT, lineWord(1, 0, 1, 6'h3f), 2'h0);
		readCheck("high lane", `LGR_IDX_RIGHT, 32'h10c, 2'h0);
		check("right muted", 32'(rightLine), 32'hc2);
		wStrb <= 4'h3;

		// Mid-run reset restores unity gain and clears controls
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("left after reset", 32'(leftLine), 32'h72);
		check("right after reset", 32'(rightLine), 32'h72);
		check("ref after reset", 32'(refCtrl), 32'h0);

		// Unmapped index refused
		axiWrite(7'h07, 32'h1, 2'h2);
		readCheck("unmapped", 7'h07, 32'h0, 2'h2);
		stop_test();
	end

	// Guard against a hang
	initial begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		stop_test();
	end
endmodule
`default_nettype wire
